// [verilog/bcf_defs.svh]
`ifndef BCF_DEFS_SVH
`define BCF_DEFS_SVH
`define BCF_CMD_LEN        4'd9
`define BCF_CAN_LEN        4'd7
`define BCF_REPLY_LEN      4'd9
`define BCF_CAN_REPLY_LEN  4'd7
`define BCF_ST_OK          8'h64
`define BCF_ST_STORED      8'h65
`define BCF_ST_CKSUM       8'h01
`define BCF_ST_BAD_CMD     8'h02
`define BCF_ST_BAD_TYPE    8'h03
`define BCF_ST_BAD_VALUE   8'h04
`define BCF_ST_LOCKED      8'h05
`define BCF_ST_UNAVAIL     8'h06
`define BCF_GAP_W          16
`define BCF_GAP_DEFAULT    16'h0FA0
`endif

// [verilog/bcf_pkg.sv]
`default_nettype none
package bcf_pkg;
    typedef enum logic [4:0] {
        BCF_IDLE  = 5'b00001,
        BCF_RECV  = 5'b00010,
        BCF_EXEC  = 5'b00100,
        BCF_SEND  = 5'b01000,
        BCF_DROP  = 5'b10000
    } bcf_state_t;
endpackage
`default_nettype wire

// [verilog/bcf_sum_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface bcf_sum_if;
    logic       clr;
    logic       add;
    logic [7:0] data;
    logic [7:0] sum;
    modport owner (output clr, output add, output data, input sum);
    modport acc   (input clr, input add, input data, output sum);
endinterface
`default_nettype wire

// [verilog/bcf_sum.sv]
`timescale 1ns/10ps
`default_nettype none
module bcf_sum (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Accumulator port
    bcf_sum_if.acc    s
);
    logic [7:0] sum_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sum_q <= 8'h00;
        end else if (s.clr) begin
            sum_q <= s.add ? s.data : 8'h00;
        end else if (s.add) begin
            sum_q <= sum_q + s.data;
        end
    end
    assign s.sum = sum_q;
endmodule // bcf_sum
`default_nettype wire

// [verilog/bcf_frame.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bcf_defs.svh"
// Functional notes
// - The block only transmits as the answer to a received command.
// - A serial command is address, command, type, bank, four value bytes, checksum.
// - The value field is four bytes, most significant first.
// - The command checksum is the 8-bit sum of the eight bytes before it.
// - Every accepted command gets exactly one reply.
// - A serial reply is reply address, module address, status, command, value, checksum.
// - The reply checksum is the 8-bit sum of all other reply bytes.
// - Status is 100 ok, 101 stored, 1 checksum, 2 command, 3 type, 4 value, 5 locked, 6 unavailable.
// - On CAN a command is the seven-byte body; the identifier is the address.
// - On CAN the reply drops the reply address and checksum bytes; the module address stays.
module bcf_frame (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Configuration
    input  wire logic        can_mode,
    input  wire logic [7:0]  module_addr,
    input  wire logic [7:0]  reply_addr,
    input  wire logic [15:0] gap_limit,
    // Received byte stream
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    // Decoded command to the executor
    output logic             cmd_valid,
    output logic [7:0]       cmd_num,
    output logic [7:0]       cmd_type,
    output logic [7:0]       cmd_bank,
    output logic [31:0]      cmd_value,
    // Executor result
    input  wire logic        res_valid,
    input  wire logic [7:0]  res_status,
    input  wire logic [31:0] res_value,
    // Transmitted byte stream
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    output logic             tx_busy
);
    // ==========================================
    // State and synchronisers
    bcf_pkg::bcf_state_t state_q;
    logic [3:0]  idx_q;
    logic [7:0]  buf_q [0:8];
    logic [15:0] gap_q;
    logic [3:0]  tx_idx_q;
    logic [7:0]  rep_q [0:8];
    logic        can_m1_q;
    logic        can_q;
    logic [3:0]  rx_len;
    logic [3:0]  tx_len;
    logic        frame_end;
    logic        cksum_ok;
    logic        cksum_ok_q;
    logic [7:0]  st_sel;

    bcf_sum_if rx_sum ();
    bcf_sum_if tx_sum ();
    bcf_sum u_rx_sum (.clk(clk), .sys_rst(sys_rst), .s(rx_sum));
    bcf_sum u_tx_sum (.clk(clk), .sys_rst(sys_rst), .s(tx_sum));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            can_m1_q <= 1'b0;
            can_q    <= 1'b0;
        end else begin
            can_m1_q <= can_mode;
            can_q    <= can_m1_q;
        end
    end

    assign rx_len    = can_q ? `BCF_CAN_LEN : `BCF_CMD_LEN;
    assign tx_len    = can_q ? `BCF_CAN_REPLY_LEN : `BCF_REPLY_LEN;
    assign frame_end = rx_valid && (idx_q == rx_len - 4'd1);
    assign cksum_ok  = (rx_sum.sum == rx_data);

    // ==========================================
    // Receive checksum accumulator
    always_comb begin
        rx_sum.clr  = (state_q != bcf_pkg::BCF_RECV);
        rx_sum.add  = rx_valid && !frame_end
                      && (state_q == bcf_pkg::BCF_IDLE
                          || state_q == bcf_pkg::BCF_RECV);
        rx_sum.data = rx_data;
    end

    // ==========================================
    // Frame state machine
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= bcf_pkg::BCF_IDLE;
            idx_q   <= 4'h0;
        end else begin
            unique case (state_q)
                bcf_pkg::BCF_IDLE: begin
                    if (rx_valid) begin
                        idx_q   <= 4'h1;
                        state_q <= bcf_pkg::BCF_RECV;
                    end
                end
                bcf_pkg::BCF_RECV: begin
                    if (gap_q >= gap_limit && !rx_valid) begin
                        idx_q   <= 4'h0;
                        state_q <= bcf_pkg::BCF_IDLE;
                    end else if (frame_end) begin
                        idx_q <= 4'h0;
                        if (!can_q && buf_q[0] != module_addr) begin
                            state_q <= bcf_pkg::BCF_IDLE;
                        end else begin
                            state_q <= bcf_pkg::BCF_EXEC;
                        end
                    end else if (rx_valid) begin
                        idx_q <= idx_q + 4'd1;
                    end
                end
                bcf_pkg::BCF_EXEC: begin
                    if (res_valid || !cksum_ok_q) begin
                        state_q <= bcf_pkg::BCF_SEND;
                    end
                end
                bcf_pkg::BCF_SEND: begin
                    if (tx_ready && tx_idx_q == tx_len) begin
                        state_q <= bcf_pkg::BCF_IDLE;
                    end
                end
                bcf_pkg::BCF_DROP: begin
                    state_q <= bcf_pkg::BCF_IDLE;
                end
                default: state_q <= bcf_pkg::BCF_IDLE;
            endcase
        end
    end

    // ==========================================
    // Byte store and checksum result
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 9; i++) begin
                buf_q[i] <= 8'h00;
            end
            cksum_ok_q <= 1'b0;
        end else if (rx_valid && (state_q == bcf_pkg::BCF_IDLE
                                  || state_q == bcf_pkg::BCF_RECV)) begin
            buf_q[idx_q] <= rx_data;
            if (frame_end) begin
                cksum_ok_q <= can_q || cksum_ok;
            end
        end
    end

    // ==========================================
    // Inter-byte gap timer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_q <= 16'h0000;
        end else if (rx_valid || state_q != bcf_pkg::BCF_RECV) begin
            gap_q <= 16'h0000;
        end else if (gap_q != 16'hFFFF) begin
            gap_q <= gap_q + 16'd1;
        end
    end

    // ==========================================
    // Command handoff
    logic [3:0] b0;
    assign b0 = can_q ? 4'd0 : 4'd1;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_valid <= 1'b0;
            cmd_num   <= 8'h00;
            cmd_type  <= 8'h00;
            cmd_bank  <= 8'h00;
            cmd_value <= 32'h0000_0000;
        end else begin
            cmd_valid <= state_q == bcf_pkg::BCF_RECV && frame_end
                         && (can_q || buf_q[0] == module_addr)
                         && (can_q || cksum_ok);
            if (frame_end) begin
                cmd_num   <= buf_q[b0];
                cmd_type  <= buf_q[b0 + 4'd1];
                cmd_bank  <= buf_q[b0 + 4'd2];
                cmd_value <= {buf_q[b0 + 4'd3], buf_q[b0 + 4'd4],
                              buf_q[b0 + 4'd5],
                              can_q ? rx_data : buf_q[b0 + 4'd6]};
            end
        end
    end

    // ==========================================
    // Reply assembly
    assign st_sel = cksum_ok_q ? res_status : `BCF_ST_CKSUM;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 9; i++) begin
                rep_q[i] <= 8'h00;
            end
        end else if (state_q == bcf_pkg::BCF_EXEC
                     && (res_valid || !cksum_ok_q)) begin
            if (can_q) begin
                rep_q[0] <= module_addr;
                rep_q[1] <= st_sel;
                rep_q[2] <= cmd_num;
                rep_q[3] <= res_value[31:24];
                rep_q[4] <= res_value[23:16];
                rep_q[5] <= res_value[15:8];
                rep_q[6] <= res_value[7:0];
            end else begin
                rep_q[0] <= reply_addr;
                rep_q[1] <= module_addr;
                rep_q[2] <= st_sel;
                rep_q[3] <= cmd_num;
                rep_q[4] <= res_value[31:24];
                rep_q[5] <= res_value[23:16];
                rep_q[6] <= res_value[15:8];
                rep_q[7] <= res_value[7:0];
            end
        end
    end

    // ==========================================
    // Transmit sequencer
    logic [7:0] tx_byte;
    always_comb begin
        if (!can_q && tx_idx_q == `BCF_REPLY_LEN - 4'd1) begin
            // Last value byte is accepted on the same edge
            tx_byte = tx_sum.sum + tx_data;
        end else begin
            tx_byte = rep_q[tx_idx_q];
        end
        tx_sum.clr  = (state_q != bcf_pkg::BCF_SEND);
        tx_sum.add  = (state_q == bcf_pkg::BCF_SEND) && tx_valid
                      && tx_ready;
        tx_sum.data = tx_data;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_idx_q <= 4'h0;
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_last  <= 1'b0;
            tx_busy  <= 1'b0;
        end else if (state_q == bcf_pkg::BCF_SEND) begin
            tx_busy <= 1'b1;
            if (!tx_valid || tx_ready) begin
                if (tx_idx_q < tx_len) begin
                    tx_valid <= 1'b1;
                    tx_data  <= tx_byte;
                    tx_last  <= (tx_idx_q == tx_len - 4'd1);
                    tx_idx_q <= tx_idx_q + 4'd1;
                end else begin
                    tx_valid <= 1'b0;
                    tx_last  <= 1'b0;
                end
            end
        end else begin
            tx_idx_q <= 4'h0;
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
            tx_busy  <= 1'b0;
        end
    end

    // ==========================================
    // Checks
    only_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
        tx_valid |-> state_q == bcf_pkg::BCF_SEND)
        else $error("transmit outside reply");
    bad_sum_status_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == bcf_pkg::BCF_EXEC && !cksum_ok_q && !can_q)
        |=> rep_q[2] == `BCF_ST_CKSUM)
        else $error("checksum status wrong");
    addr_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == bcf_pkg::BCF_RECV && frame_end && !can_q
         && buf_q[0] != module_addr) |=> state_q == bcf_pkg::BCF_IDLE)
        else $error("foreign frame not dropped");
    gap_abort_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == bcf_pkg::BCF_RECV && gap_q >= gap_limit && !rx_valid)
        |=> state_q == bcf_pkg::BCF_IDLE)
        else $error("gap timeout ignored");
    one_reply_a: assert property (@(posedge clk) disable iff (sys_rst)
        (tx_valid && tx_ready && tx_last) |=> !tx_valid)
        else $error("extra reply byte");
    reply_head_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == bcf_pkg::BCF_SEND && tx_idx_q == 4'h0 && !can_q)
        |=> tx_data == reply_addr)
        else $error("reply address wrong");
    cmd_sum_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_valid && !can_q |-> $past(cksum_ok))
        else $error("bad checksum accepted");
    frame_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_valid |-> $past(idx_q) == rx_len - 4'd1)
        else $error("frame length wrong");
endmodule // bcf_frame
`default_nettype wire

// [tb/bcf_host.sv]
`timescale 1ns/10ps
`default_nettype none
module bcf_host (
    // Clock
    input  wire logic  clk,
    // Command bytes out
    output logic       rx_valid,
    output logic [7:0] rx_data,
    // Reply bytes in
    input  wire logic  tx_valid,
    input  wire logic  tx_last,
    output logic       tx_ready
);
    logic stall;

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b1;
        stall    = 1'b0;
    end

    // ========================================
    // Ready line, random stalls when enabled
    always @(negedge clk) begin
        tx_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
    end

    // ========================================
    // Frame sender, bytes taken from the top
    task automatic send(input logic [71:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data  = f[71-8*i -: 8];
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask

    // Next command only after the reply
    task automatic wait_reply();
        for (int k = 0; k < 3000; k++) begin
            @(posedge clk);
            if (tx_valid === 1'b1 && tx_ready && tx_last === 1'b1) break;
        end
        @(negedge clk);
    endtask
endmodule // bcf_host
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        can_mode = 1'b0;
    logic [7:0]  module_addr = 8'h3C;
    logic [7:0]  reply_addr = 8'h02;
    logic [15:0] gap_limit = 16'h0014;
    logic        rx_valid, tx_valid, tx_last, tx_ready, tx_busy, cmd_valid;
    logic [7:0]  rx_data, tx_data, cmd_num, cmd_type, cmd_bank;
    logic [31:0] cmd_value;
    logic        res_valid = 1'b0;
    logic [7:0]  res_status = 8'h00;
    logic [31:0] res_value = 32'h0;
    logic [7:0]  e_num, e_type, e_bank, e_st;
    logic [31:0] e_val;
    logic [8:0]  exp_q[$];
    logic [8:0]  note;
    logic [7:0]  codes [8] = '{8'h64, 8'h65, 8'h01, 8'h02,
                               8'h03, 8'h04, 8'h05, 8'h06};
    int          fails = 0, total_checks = 0, cycles = 0;
    int          n_cmd = 0, e_cmd = 0, e_dly = 0;

    always #20 clk = ~clk;

    bcf_frame u_dut (.clk(clk), .sys_rst(sys_rst), .can_mode(can_mode),
        .module_addr(module_addr), .reply_addr(reply_addr),
        .gap_limit(gap_limit), .rx_valid(rx_valid), .rx_data(rx_data),
        .cmd_valid(cmd_valid), .cmd_num(cmd_num), .cmd_type(cmd_type),
        .cmd_bank(cmd_bank), .cmd_value(cmd_value), .res_valid(res_valid),
        .res_status(res_status), .res_value(res_value),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .tx_busy(tx_busy));

    bcf_host u_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));

    // ========================================
    // Compare and close
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    // ========================================
    // Executor stand-in
    always @(posedge clk) begin
        if (!sys_rst && cmd_valid === 1'b1) begin
            n_cmd++;
            chk({cmd_num, cmd_type, cmd_bank}, {8'h00, e_num, e_type, e_bank});
            chk(cmd_value, e_val);
            repeat (e_dly) @(negedge clk);
            @(negedge clk);
            res_valid  = 1'b1;
            res_status = e_st;
            @(negedge clk);
            res_valid  = 1'b0;
        end
    end

    // ========================================
    // Reply monitor
    always @(posedge clk) begin
        if (!sys_rst && tx_valid === 1'b1 && tx_ready) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, tx_data, 8'h00);
            end else begin
                note = exp_q.pop_front();
                if (note[8]) chk(tx_data, note[7:0]);
                chk(tx_last, exp_q.size() == 0);
                chk(tx_busy, 1'b1);
            end
        end
    end

    // ========================================
    // Expected reply and command tasks
    task automatic push(input logic [7:0] st);
        logic [7:0] b [9];
        b = '{reply_addr, module_addr, st, e_num, res_value[31:24],
              res_value[23:16], res_value[15:8], res_value[7:0], 8'h00};
        for (int i = 0; i < 8; i++) b[8] = b[8] + b[i];
        if (can_mode) begin
            for (int i = 1; i < 8; i++) exp_q.push_back({1'b1, b[i]});
        end else begin
            for (int i = 0; i < 9; i++) exp_q.push_back({1'b1, b[i]});
        end
    endtask

    task automatic run(input logic [7:0] a, input logic bad,
                       input logic [7:0] st);
        logic [71:0] f;
        logic [7:0]  s;
        logic        ok;
        e_num     = 8'($urandom);
        e_type    = 8'($urandom);
        e_bank    = 8'($urandom);
        e_val     = $urandom;
        e_st      = st;
        e_dly     = $urandom_range(6);
        res_value = $urandom;
        ok = can_mode || (a == module_addr);
        s = a + e_num + e_type + e_bank + e_val[31:24] + e_val[23:16]
            + e_val[15:8] + e_val[7:0];
        if (can_mode) f = {e_num, e_type, e_bank, e_val, 16'h0000};
        else f = {a, e_num, e_type, e_bank, e_val, s ^ {7'h00, bad}};
        if (ok && !bad) e_cmd++;
        if (ok) push(bad ? 8'h01 : st);
        u_host.send(f, can_mode ? 7 : 9);
        if (ok) u_host.wait_reply();
        else repeat (40) @(negedge clk);
    endtask

    // ========================================
    // Main sequence
    initial begin
        void'($urandom(32'hC32C));
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        foreach (codes[i]) begin
            u_host.stall = i[0];
            run(module_addr, 1'b0, codes[i]);
        end
        run(module_addr, 1'b1, 8'h64);
        run(module_addr ^ 8'h01, 1'b0, 8'h64);
        u_host.send({module_addr, 64'h0}, 4);
        repeat (gap_limit + 4) @(negedge clk);
        run(module_addr, 1'b0, 8'h65);
        can_mode = 1'b1;
        repeat (4) @(negedge clk);
        run(8'h00, 1'b0, 8'h64);
        run(8'h00, 1'b0, 8'h02);
        repeat (20) @(negedge clk);
        chk(n_cmd, e_cmd);
        chk(exp_q.size(), 0);
        chk(tx_busy, 1'b0);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
